/* pkg/btwd_defines.svh */
`ifndef BTWD_DEFINES_SVH
`define BTWD_DEFINES_SVH
// ----------------------------------------
// Register addresses and fields
// ----------------------------------------
`define BTWD_CTRL_ADDR 8'hD3
`define BTWD_CNT_ADDR 8'hFD
`define BTWD_CTRL_RESET 8'h00
`define BTWD_KEY_DISABLE 4'hA
`define BTWD_KEY_MSB 7
`define BTWD_KEY_LSB 4
`define BTWD_SEL_MSB 3
`define BTWD_SEL_LSB 2
`define BTWD_CNT_CLR_BIT 1
`define BTWD_DIV_CLR_BIT 0
// ----------------------------------------
// Divider taps
// ----------------------------------------
`define BTWD_DIV_4096 4096
`define BTWD_DIV_1024 1024
`define BTWD_DIV_128 128
`define BTWD_PRESCALE_W 12
`define BTWD_TAP_4096 11
`define BTWD_TAP_1024 9
`define BTWD_TAP_128 6
`endif

/* pkg/btwd_pkg.sv */
package btwd_pkg;
   typedef enum logic [1:0] {
      BTWD_SEL_4096,
      BTWD_SEL_1024,
      BTWD_SEL_128,
      BTWD_SEL_NONE
   } btwd_sel_t;
endpackage

/* pkg/btwd_div_if.sv */
`timescale 1ns/100ps
interface btwd_div_if;
   logic clear;
   logic [1:0] sel;
   logic tick;
   modport ctl (output clear, output sel, input tick);
   modport div (input clear, input sel, output tick);
endinterface

/* rtl/btwd_prescaler.sv */
`timescale 1ns/100ps
`include "btwd_defines.svh"
module btwd_prescaler import btwd_pkg::*; #(
   parameter int W = `BTWD_PRESCALE_W
) (
   input wire logic CLK,
   input wire logic RST_N,
   btwd_div_if.div bus,
   output logic [W-1:0] div_q
);
   logic [W-1:0] cnt_r;
   logic [W-1:0] cnt_nxt;
   logic tick_r;

   // True when the tap bit drops, once per full period of that tap
   function automatic logic tap_fall(input logic [W-1:0] cur, input logic [W-1:0] nxt, input int unsigned tap);
      tap_fall = cur[tap] & ~nxt[tap];
   endfunction

   // ----------------------------------------
   // Free divider and tap select
   // ----------------------------------------
   assign cnt_nxt = cnt_r + {{(W-1){1'b0}}, 1'b1};
   assign div_q = cnt_r;
   assign bus.tick = tick_r;

   // Counts oscillator clocks, restart on clear
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         cnt_r <= '0;
      end else if (bus.clear) begin
         cnt_r <= '0;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end

   // One pulse per tap carry
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         tick_r <= 1'b0;
      end else if (bus.clear) begin
         tick_r <= 1'b0;
      end else begin
         case (btwd_sel_t'(bus.sel))
            BTWD_SEL_4096: tick_r <= tap_fall(cnt_r, cnt_nxt, `BTWD_TAP_4096);
            BTWD_SEL_1024: tick_r <= tap_fall(cnt_r, cnt_nxt, `BTWD_TAP_1024);
            BTWD_SEL_128: tick_r <= tap_fall(cnt_r, cnt_nxt, `BTWD_TAP_128);
            default: tick_r <= 1'b0;
         endcase
      end
   end
endmodule // btwd_prescaler

/* rtl/btwd_top.sv */
`timescale 1ns/100ps
`include "btwd_defines.svh"
module btwd_top import btwd_pkg::*; #(
   parameter int CNT_W = 8
) (
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic [7:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [7:0] RDATA,
   output logic SYS_RESET,
   output logic WDT_ENABLED,
   output logic T0_DIV_CLEAR
);
   // ----------------------------------------
   // Timing notes
   // ----------------------------------------
   // A control write is taken at the edge that sees WR high with the control address.
   // The control register changes at that edge; the armed flag follows one edge later.
   // Read data appears one edge after RD and stands until the next read.
   // The counter steps one edge after each divider tick; a reset request comes at that same edge.
   // Software must write the counter clear often enough to stay ahead of the overflow.
   // Select 11 stops the divider ticks, so the watchdog never fires while it is chosen.

   // ----------------------------------------
   // Internal signals
   // ----------------------------------------
   // Select, clear and tick shared with the prescaler
   btwd_div_if div_bus();

   // Control register and the value a write loads
   logic [7:0] ctrl_r;
   logic [7:0] ctrl_nxt;

   // Fields of the stored control value
   logic [3:0] key_field;
   logic [1:0] sel_field;

   // Timebase counter and its next count
   logic [CNT_W-1:0] cnt_r;
   logic [CNT_W-1:0] cnt_nxt;

   // Address decode of the bus strobes
   logic wr_ctrl;
   logic rd_ctrl;
   logic rd_cnt;

   // Write-one strobes taken from a control write
   logic cnt_clr;
   logic div_clr;

   // Watchdog state
   logic wdt_en;
   logic overflow;
   logic srst_nxt;

   // Next read data
   logic [7:0] rdata_nxt;

   // ----------------------------------------
   // Helper functions
   // ----------------------------------------
   // True unless the key field holds the disable pattern
   function automatic logic key_enables(input logic [3:0] key);
      key_enables = (key != `BTWD_KEY_DISABLE);
   endfunction

   // True when the bus address names the given register
   function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] reg_addr);
      addr_hit = (addr == reg_addr);
   endfunction

   // True when a taken control write carries a one in a strobe bit
   function automatic logic strobe_hit(input logic wr, input logic bit_val);
      strobe_hit = wr & bit_val;
   endfunction

   // ----------------------------------------
   // Address decode
   // ----------------------------------------
   // Only the control address takes writes; a write to the counter address is dropped
   assign wr_ctrl = WR & addr_hit(ADDR, `BTWD_CTRL_ADDR);
   // Reads of the two registers; anything else reads zero
   assign rd_ctrl = RD & addr_hit(ADDR, `BTWD_CTRL_ADDR);
   assign rd_cnt = RD & addr_hit(ADDR, `BTWD_CNT_ADDR);

   // ----------------------------------------
   // Write-one strobes
   // ----------------------------------------
   // Counter clear; a zero in this bit leaves the counter alone
   assign cnt_clr = strobe_hit(wr_ctrl, WDATA[`BTWD_CNT_CLR_BIT]);
   // Divider clear; a zero in this bit leaves both dividers alone
   assign div_clr = strobe_hit(wr_ctrl, WDATA[`BTWD_DIV_CLR_BIT]);

   // ----------------------------------------
   // Control register
   // ----------------------------------------
   // Key and select are kept; the strobe bits are never stored, so they read zero
   assign ctrl_nxt = {WDATA[`BTWD_KEY_MSB:`BTWD_SEL_LSB], 2'h0};

   // Loaded by each control write, cleared by reset
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         ctrl_r <= `BTWD_CTRL_RESET;
      end else if (wr_ctrl) begin
         ctrl_r <= ctrl_nxt;
      end
   end

   // Key and clock select fields as stored
   assign key_field = ctrl_r[`BTWD_KEY_MSB:`BTWD_KEY_LSB];
   assign sel_field = ctrl_r[`BTWD_SEL_MSB:`BTWD_SEL_LSB];

   // Any key but the disable pattern keeps the watchdog armed
   assign wdt_en = key_enables(key_field);

   // ----------------------------------------
   // Prescaler
   // ----------------------------------------
   // Timer 0 has its own divider, cleared through T0_DIV_CLEAR; a divider clear restarts this one
   assign div_bus.sel = sel_field;
   assign div_bus.clear = div_clr;

   // Free running divider, one tick per period of the selected tap
   btwd_prescaler u_pre (
      .CLK(CLK),
      .RST_N(RST_N),
      .bus(div_bus),
      .div_q()
   );

   // ----------------------------------------
   // Timebase counter
   // ----------------------------------------
   // Next count; all ones wraps to zero
   assign cnt_nxt = cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};

   // Steps once per divider tick; a clear write wins over a tick in the same cycle
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         cnt_r <= '0;
      end else if (cnt_clr) begin
         cnt_r <= '0;
      end else if (div_bus.tick) begin
         cnt_r <= cnt_nxt;
      end
   end

   // ----------------------------------------
   // Watchdog reset
   // ----------------------------------------
   // The tick that carries the counter past all ones
   assign overflow = div_bus.tick & (&cnt_r);

   // A counter clear in the overflow cycle rescues the system
   assign srst_nxt = overflow & wdt_en & ~cnt_clr;

   // One-cycle system reset request
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         SYS_RESET <= 1'h0;
      end else begin
         SYS_RESET <= srst_nxt;
      end
   end

   // Watchdog armed flag, one cycle behind the key field
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         WDT_ENABLED <= 1'h1;
      end else begin
         WDT_ENABLED <= wdt_en;
      end
   end

   // ----------------------------------------
   // Timer 0 divider clear
   // ----------------------------------------
   // One-cycle pulse per divider clear write, for the timer 0 divider
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         T0_DIV_CLEAR <= 1'h0;
      end else begin
         T0_DIV_CLEAR <= div_clr;
      end
   end

   // ----------------------------------------
   // Read port
   // ----------------------------------------
   // Read mux; the counter is read but never written
   always_comb begin
      rdata_nxt = 8'h00;
      if (rd_ctrl) begin
         rdata_nxt = ctrl_r;
      end else if (rd_cnt) begin
         rdata_nxt = 8'(cnt_r);
      end
   end

   // Read data is loaded on each read and holds until the next one
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         RDATA <= 8'h00;
      end else if (RD) begin
         RDATA <= rdata_nxt;
      end
   end
endmodule // btwd_top

/* verification/btwd_checker.sv */
`timescale 1ns/100ps
module btwd_checker (
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic [7:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   input wire logic [7:0] RDATA,
   input wire logic SYS_RESET,
   input wire logic WDT_ENABLED,
   input wire logic T0_DIV_CLEAR
);
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RST_N);
   // Control register write
   wire logic cw = WR && ADDR == 8'hD3;
   AST_KEY: assert property (cw |-> ##2 WDT_ENABLED == ($past(WDATA[7:4], 2) != 4'hA))
      else $error("enable vs key");
   AST_SRST: assert property (SYS_RESET |-> $past(WDT_ENABLED) || $past(WDT_ENABLED, 2))
      else $error("reset while off");
   AST_CCLR: assert property (cw && WDATA[1] ##2 RD && ADDR == 8'hFD |=> RDATA == 8'h00)
      else $error("count not cleared");
   AST_DCLR: assert property (cw && WDATA[0] |=> T0_DIV_CLEAR)
      else $error("no divider clear");
   AST_DSRC: assert property (T0_DIV_CLEAR |-> $past(cw && WDATA[0]))
      else $error("stray divider clear");
   AST_SELF: assert property (RD && ADDR == 8'hD3 |=> RDATA[1:0] == 2'b00)
      else $error("strobe bits read 1");
endmodule // btwd_checker
bind btwd_top btwd_checker u_chk (.CLK(CLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
   .RD(RD), .RDATA(RDATA), .SYS_RESET(SYS_RESET), .WDT_ENABLED(WDT_ENABLED), .T0_DIV_CLEAR(T0_DIV_CLEAR));

/* verification/basic_timer_watchdog_control_test.sv */
`timescale 1ns/100ps
module basic_timer_watchdog_control_test;
   logic CLK = 1'b0;
   logic RST_N = 1'b0;
   logic [7:0] ADDR = 8'h00;
   logic [7:0] WDATA = 8'h00;
   logic WR = 1'b0;
   logic RD = 1'b0;
   logic [7:0] RDATA;
   logic SYS_RESET;
   logic WDT_ENABLED;
   logic T0_DIV_CLEAR;
   int err_count = 0;
   int check_count = 0;
   int n;
   int dv [4] = '{4096, 1024, 128, 128};
   always #5 CLK = ~CLK;
   btwd_top DUT (.CLK(CLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
      .SYS_RESET(SYS_RESET), .WDT_ENABLED(WDT_ENABLED), .T0_DIV_CLEAR(T0_DIV_CLEAR));
   task automatic report_and_stop;
      if (err_count == 0 && check_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      check_count++;
      if (g !== e) begin
         err_count++;
         $display("CHECK FAILED %0t %h %h", $time, g, e);
      end
   endtask
   // Register write and read cycles
   task automatic wr(input logic [7:0] d);
      @(posedge CLK);
      ADDR <= 8'hD3;
      WDATA <= d;
      WR <= 1'b1;
      @(posedge CLK);
      WR <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge CLK);
      ADDR <= a;
      RD <= 1'b1;
      @(posedge CLK);
      RD <= 1'b0;
      #1 chk(RDATA, e);
   endtask
   // Every key value
   task automatic t_keys;
      for (int k = 0; k < 16; k++) begin
         wr({k[3:0], 4'h0});
         @(posedge CLK);
         #1 chk({7'h00, WDT_ENABLED}, {7'h00, k != 10});
      end
   endtask
   // Every clock select, with both clears
   task automatic t_sel;
      for (int s = 0; s < 4; s++) begin
         wr({4'h0, s[1:0], 2'b11});
         #1 chk({7'h00, T0_DIV_CLEAR}, 8'h01);
         rd(8'hFD, 8'h00);
         repeat (dv[s] * 3 / 2) @(posedge CLK);
         rd(8'hFD, {7'h00, s != 3});
         wr({4'h0, s[1:0], 2'b00});
         #1 chk({7'h00, T0_DIV_CLEAR}, 8'h00);
         rd(8'hFD, {7'h00, s != 3});
         rd(8'hD3, {4'h0, s[1:0], 2'b00});
      end
   endtask
   // Overflow resets only while enabled
   task automatic t_ovf;
      wr(8'h0B);
      n = 0;
      while (SYS_RESET !== 1'b1 && n < 34000) begin
         @(posedge CLK);
         #1 n++;
      end
      chk({7'h00, n > 32000 && n < 33600}, 8'h01);
      if (n >= 34000) report_and_stop;
      wr(8'hAB);
      n = 0;
      repeat (33000) begin
         @(posedge CLK);
         #1 n += SYS_RESET;
      end
      chk(n[7:0], 8'h00);
   endtask
   initial begin
      repeat (16) @(posedge CLK);
      RST_N <= 1'b1;
      #1 chk({6'h00, WDT_ENABLED, SYS_RESET}, 8'h02);
      t_keys;
      t_sel;
      t_ovf;
      report_and_stop;
   end
endmodule // basic_timer_watchdog_control_test
